// ### logic/perf_pkg.sv
// shared constants for the performance event counting block
`default_nettype none
package perf_pkg;
   // special register numbers of the move-to/move-from port
   localparam logic [9:0] SPR_MIRROR0 = 10'h3A8; // 936, read-only copy of primary control
   localparam logic [9:0] SPR_MIRROR1 = 10'h3AC; // 940, read-only copy of second control
   localparam logic [9:0] SPR_PRIMARY = 10'h3B8; // 952, primary control
   localparam logic [9:0] SPR_CNT1 = 10'h3B9; // 953
   localparam logic [9:0] SPR_CNT2 = 10'h3BA; // 954
   localparam logic [9:0] SPR_SECOND = 10'h3BC; // 956, second control
   localparam logic [9:0] SPR_CNT3 = 10'h3BD; // 957
   localparam logic [9:0] SPR_CNT4 = 10'h3BE; // 958

   // primary control fields, bit 0 is the most significant bit
   localparam int GIE_BIT = 5; // global interrupt enable
   localparam int FREEZE_BIT = 6; // freeze counters on interrupt
   localparam int TBSEL_HI = 7; // time-base bit field, bits 7..8
   localparam int TBSEL_LO = 8;
   localparam int THR_HI = 10; // latency threshold, bits 10..15
   localparam int THR_LO = 15;
   localparam int C1IE_BIT = 16; // counter one interrupt enable
   localparam int SHIE_BIT = 17; // shared enable for counters two to four
   localparam int SEL1_HI = 19; // counter one selector, bits 19..25
   localparam int SEL1_LO = 25;
   localparam int SEL2_HI = 26; // counter two selector, bits 26..31
   localparam int SEL2_LO = 31;

   // second control fields
   localparam int SEL3_HI = 0; // counter three selector, bits 0..4
   localparam int SEL3_LO = 4;
   localparam int SEL4_HI = 5; // counter four selector, bits 5..9
   localparam int SEL4_LO = 9;
   localparam logic [0:31] SECOND_WMASK = 32'hFFC0_0000; // bits 10..31 reserved

   // reset values
   localparam logic [0:31] PRIMARY_RST = 32'h0000_0000;
   localparam logic [0:31] SECOND_RST = 32'h0000_0000;
   localparam logic [0:31] CNT_RST = 32'h0000_0000;

   // shared event codes for counters one and two
   localparam int N_CODES = 13; // codes 0..12 are defined
   localparam int CODE_TB = 3; // time-base transition event
   localparam int CODE_COMMON_LAST = 4; // counters three and four share codes 1..4

   // time-base lower bit picked by each setting of the two-bit field
   localparam int TB_PICK0 = 15;
   localparam int TB_PICK1 = 19;
   localparam int TB_PICK2 = 23;
   localparam int TB_PICK3 = 31;
endpackage
`default_nettype wire

// ### logic/evt_counter.sv
// one 32-bit event counter with software load
`default_nettype none
module evt_counter
   import perf_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic nrst, // async reset, active low
   input wire logic wr_en, // software load this cycle
   input wire logic [0:31] wdata, // value to load
   input wire logic run, // counting allowed
   input wire logic [1:0] inc, // occurrences this cycle, 0..2
   output logic [0:31] value_q // counter, bit 0 is the overflow indicator
);
   logic [0:31] value_d; // next count

   // load beats counting so software always sees its own value
   always_comb begin
      if (wr_en) begin
         value_d = wdata;
      end else if (run) begin
         // RL25 add full count
         value_d = value_q + {30'h0000_0000, inc};
      end else begin
         value_d = value_q; // frozen, counting not allowed
      end
   end

   // plain register; overflow is the top bit, not a separate flag
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) value_q <= CNT_RST;
      else value_q <= value_d;
   end
endmodule
`default_nettype wire

// ### logic/sel_decode.sv
// maps a counter selector code onto the occurrence count of its event
`default_nettype none
module sel_decode
   import perf_pkg::*;
#(
   parameter int SEL_W = 7 // selector width
) (
   input wire logic [SEL_W-1:0] sel, // selector code
   input wire logic [1:0] amt [0:N_CODES-1], // occurrences per defined code
   output logic [1:0] inc // occurrences of the chosen event
);
   // codes above 12 are reserved and count nothing
   wire in_range = (sel < SEL_W'(N_CODES));

   // code 0 yields zero through the table, so the counter holds
   assign inc = in_range ? amt[sel[3:0]] : 2'h0;
endmodule
`default_nettype wire

// ### logic/perf_event_counters.sv
// performance monitor: four event counters, control registers and interrupt
`default_nettype none

// How it works
// RL1: primary control mirrored read-only at 936
// RL2: second control bits 0-4 select counter three
// RL3: bits 5-9 select counter four; rest reserved
// RL4: second control read/write at 956
// RL5: second control mirrored read-only at 940
// RL6: four 32-bit counters, overflow may interrupt
// RL7: bit 0 overflow, bits 1-31 count
// RL8: overflow when top bit becomes one
// RL9: interrupt needs global and matching enable
// RL10: interrupt pends until external enable set
// RL11: freeze bit stops counters on interrupt
// RL12: loading overflowed value may raise interrupt
// RL13: primary bits 19-31 pick events, counting window
// RL14: codes 0 hold, 1 cycles, 2 completions
// RL15: code 3 counts chosen time-base bit rises
// RL16: code 4 dispatches, code 5 barriers
// RL17: codes 6 table search, 7 L2, 8 fetch
// RL18: code 9 breakpoint match, 10 slow misses
// RL19: code 11 unresolved, 12 second-branch stall
// RL20: counter two codes mirror counter one's
// RL21: software avoids reserved selector codes
// RL22: hardware clears global enable on interrupt
// RL23: time-base field in primary bits 7-8
// RL24: six-bit latency threshold in bits 10-15
// RL25: multiple occurrences per cycle all counted
module perf_event_counters
   import perf_pkg::*;
(
   input wire logic CLOCK, // core clock, 125 MHz
   input wire logic NRST, // async reset, active low
   input wire logic [9:0] SPR_NUM, // special register number
   input wire logic SPR_WR, // move-to strobe, one cycle
   input wire logic SPR_RD, // move-from strobe, one cycle
   input wire logic [0:31] SPR_WDATA, // move-to data
   output logic [0:31] SPR_RDATA, // move-from data
   output logic SPR_RVALID, // move-from data valid, one cycle
   input wire logic [1:0] EV_COMPLETE, // instructions completed, no folded branches
   input wire logic [1:0] EV_DISPATCH, // instructions dispatched, 0..2
   input wire logic EV_BARRIER, // enforce-in-order barrier completed
   input wire logic EV_TABLE_SEARCH, // cycle in translation table search
   input wire logic EV_L2_HIT, // second-level cache hit
   input wire logic EV_FETCH_EA, // valid fetch address to memory
   input wire logic EV_BKPT_MATCH, // completion matched breakpoint register
   input wire logic EV_LOAD_MISS, // first-level load miss finished
   input wire logic [7:0] EV_LOAD_LAT, // latency of that miss in cycles
   input wire logic EV_UNRES_BR, // branch unresolved when processed
   input wire logic EV_STALL_BR2, // dispatch stall on second unresolved branch
   input wire logic [0:31] TB_LOWER, // time base lower word
   input wire logic [31:0] EV_SET3, // counter three events by code
   input wire logic [31:0] EV_SET4, // counter four events by code
   input wire logic EXT_IRQ_EN, // external-interrupt enable of the core
   input wire logic PM_EXC_TAKEN, // core took the monitor exception
   output logic PM_EXCEPTION // monitor exception request, level
);
   logic [0:31] primary_q, primary_d; // primary control register
   logic [0:31] second_q, second_d; // second control register
   logic [0:31] cnt1, cnt2, cnt3, cnt4; // counter values
   logic frozen_q, frozen_d; // counting stopped after interrupt
   logic pend_q, pend_d; // exception waiting for the core
   logic tb_prev_q; // chosen time-base bit, one cycle ago
   logic [0:31] rdata_d; // read mux
   logic [1:0] amt [0:N_CODES-1]; // occurrences per event code
   logic [1:0] inc1, inc2, inc3, inc4; // per-counter increments

   // register port decode
   wire wr_primary = SPR_WR && (SPR_NUM == SPR_PRIMARY);
   wire wr_second = SPR_WR && (SPR_NUM == SPR_SECOND);
   wire wr_c1 = SPR_WR && (SPR_NUM == SPR_CNT1);
   wire wr_c2 = SPR_WR && (SPR_NUM == SPR_CNT2);
   wire wr_c3 = SPR_WR && (SPR_NUM == SPR_CNT3);
   wire wr_c4 = SPR_WR && (SPR_NUM == SPR_CNT4);

   // primary control fields
   wire gie = primary_q[GIE_BIT];
   wire freeze_en = primary_q[FREEZE_BIT];
   // RL23 time-base field, bits 7-8
   wire [1:0] tb_sel = primary_q[TBSEL_HI:TBSEL_LO];
   wire [5:0] thresh = primary_q[THR_HI:THR_LO];
   wire c1_ie = primary_q[C1IE_BIT];
   wire sh_ie = primary_q[SHIE_BIT];
   // RL13 selectors in bits 19-31
   wire [6:0] sel1 = primary_q[SEL1_HI:SEL1_LO];
   wire [5:0] sel2 = primary_q[SEL2_HI:SEL2_LO];
   // RL2 counter three selector
   wire [4:0] sel3 = second_q[SEL3_HI:SEL3_LO];
   // RL3 counter four selector
   wire [4:0] sel4 = second_q[SEL4_HI:SEL4_LO];

   // RL15 pick time-base bit
   wire tb_bit = (tb_sel == 2'h0) ? TB_LOWER[TB_PICK0] :
                 (tb_sel == 2'h1) ? TB_LOWER[TB_PICK1] :
                 (tb_sel == 2'h2) ? TB_LOWER[TB_PICK2] : TB_LOWER[TB_PICK3];
   wire tb_rise = tb_bit && !tb_prev_q;

   // RL24 latency above threshold
   wire slow_miss = EV_LOAD_MISS && (EV_LOAD_LAT > {2'h0, thresh});

   // event table shared by counters one and two
   // RL14 hold, cycles, completions
   assign amt[0] = 2'h0;
   assign amt[1] = 2'h1;
   assign amt[2] = EV_COMPLETE;
   assign amt[3] = {1'b0, tb_rise};
   // RL16 dispatches and barriers
   assign amt[4] = EV_DISPATCH;
   assign amt[5] = {1'b0, EV_BARRIER};
   // RL17 search, L2 hit, fetch
   assign amt[6] = {1'b0, EV_TABLE_SEARCH};
   assign amt[7] = {1'b0, EV_L2_HIT};
   assign amt[8] = {1'b0, EV_FETCH_EA};
   // RL18 breakpoint and slow misses
   assign amt[9] = {1'b0, EV_BKPT_MATCH};
   assign amt[10] = {1'b0, slow_miss};
   // RL19 branch events
   assign amt[11] = {1'b0, EV_UNRES_BR};
   assign amt[12] = {1'b0, EV_STALL_BR2};

   // RL20 same table, narrower selector
   sel_decode #(.SEL_W(7)) u_pick1 (
      .sel(sel1),
      .amt(amt),
      .inc(inc1)
   );
   sel_decode #(.SEL_W(6)) u_pick2 (
      .sel(sel2),
      .amt(amt),
      .inc(inc2)
   );

   // counters three and four share codes 1..4, code 0 holds, codes 5..31 come from outside
   assign inc3 = (sel3 == 5'h00) ? 2'h0 :
                 (sel3 <= 5'(CODE_COMMON_LAST)) ? amt[sel3[2:0]] : {1'b0, EV_SET3[sel3]};
   assign inc4 = (sel4 == 5'h00) ? 2'h0 :
                 (sel4 <= 5'(CODE_COMMON_LAST)) ? amt[sel4[2:0]] : {1'b0, EV_SET4[sel4]};

   // RL8 overflow is the top bit
   wire ovf1 = cnt1[0];
   wire ovf_rest = cnt2[0] || cnt3[0] || cnt4[0];
   // RL9 qualify overflow; RL12 a loaded top bit counts too
   wire irq_fire = gie && ((c1_ie && ovf1) || (sh_ie && ovf_rest));

   // RL11 freeze after interrupt
   wire run = !frozen_q;

   // RL6 four counters; RL7 bit 0 overflow
   evt_counter u_cnt1 (
      .clk(CLOCK),
      .nrst(NRST),
      .wr_en(wr_c1),
      .wdata(SPR_WDATA),
      .run(run),
      .inc(inc1),
      .value_q(cnt1)
   );
   evt_counter u_cnt2 (
      .clk(CLOCK),
      .nrst(NRST),
      .wr_en(wr_c2),
      .wdata(SPR_WDATA),
      .run(run),
      .inc(inc2),
      .value_q(cnt2)
   );
   evt_counter u_cnt3 (
      .clk(CLOCK),
      .nrst(NRST),
      .wr_en(wr_c3),
      .wdata(SPR_WDATA),
      .run(run),
      .inc(inc3),
      .value_q(cnt3)
   );
   evt_counter u_cnt4 (
      .clk(CLOCK),
      .nrst(NRST),
      .wr_en(wr_c4),
      .wdata(SPR_WDATA),
      .run(run),
      .inc(inc4),
      .value_q(cnt4)
   );

   // control register next values
   always_comb begin
      primary_d = wr_primary ? SPR_WDATA : primary_q;
      // RL22 hardware clears global enable; wins over a same-cycle write
      if (irq_fire) primary_d[GIE_BIT] = 1'b0;
      // RL4 writable; RL3 reserved bits forced to zero
      second_d = wr_second ? (SPR_WDATA & SECOND_WMASK) : second_q;
   end

   // RL11 freeze set by interrupt, released by rewriting primary control
   assign frozen_d = (freeze_en && irq_fire) || (frozen_q && !wr_primary);
   // RL10 hold until taken; a new interrupt beats the acknowledge
   assign pend_d = irq_fire || (pend_q && !PM_EXC_TAKEN);

   // read mux; mirrors share the live registers, unmapped numbers read zero
   always_comb begin
      case (SPR_NUM)
         // RL1 primary mirror
         SPR_MIRROR0, SPR_PRIMARY: rdata_d = primary_q;
         // RL5 second mirror
         SPR_MIRROR1, SPR_SECOND: rdata_d = second_q;
         SPR_CNT1: rdata_d = cnt1;
         SPR_CNT2: rdata_d = cnt2;
         SPR_CNT3: rdata_d = cnt3;
         SPR_CNT4: rdata_d = cnt4;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // control state; writes to mirror numbers decode to nothing
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         primary_q <= PRIMARY_RST;
         second_q <= SECOND_RST;
         frozen_q <= 1'b0;
         pend_q <= 1'b0;
         tb_prev_q <= 1'b0;
      end else begin
         primary_q <= primary_d;
         second_q <= second_d;
         frozen_q <= frozen_d;
         pend_q <= pend_d;
         tb_prev_q <= tb_bit;
      end
   end

   // registered outputs: read answer and exception request
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         SPR_RDATA <= 32'h0000_0000;
         SPR_RVALID <= 1'b0;
         PM_EXCEPTION <= 1'b0;
      end else begin
         SPR_RDATA <= SPR_RD ? rdata_d : 32'h0000_0000;
         SPR_RVALID <= SPR_RD;
         // RL10 masked by external enable
         PM_EXCEPTION <= pend_q && EXT_IRQ_EN && !PM_EXC_TAKEN;
      end
   end

   // checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!NRST);

   sequence s_quiet_counters;
      !SPR_WR && frozen_q;
   endsequence

   property p_mirror0_read;
      SPR_RD && SPR_NUM == SPR_MIRROR0 |=> SPR_RVALID && SPR_RDATA == $past(primary_q);
   endproperty
   a_mirror0_read: assert property (p_mirror0_read) else $error("mirror0 read wrong"); // RL1

   property p_mirror0_ro;
      SPR_WR && SPR_NUM == SPR_MIRROR0 && !irq_fire |=> primary_q == $past(primary_q);
   endproperty
   a_mirror0_ro: assert property (p_mirror0_ro) else $error("mirror0 was written"); // RL1

   property p_reserved_zero;
      second_q[10:31] == 22'h00_0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // RL3

   property p_second_write;
      wr_second |=> second_q[SEL3_HI:SEL4_LO] == $past(SPR_WDATA[SEL3_HI:SEL4_LO]);
   endproperty
   a_second_write: assert property (p_second_write) else $error("second ctl not stored"); // RL4

   property p_mirror1_read;
      SPR_RD && SPR_NUM == SPR_MIRROR1 |=> SPR_RDATA == $past(second_q);
   endproperty
   a_mirror1_read: assert property (p_mirror1_read) else $error("mirror1 read wrong"); // RL5

   property p_gie_clear;
      irq_fire |=> !gie && pend_q;
   endproperty
   a_gie_clear: assert property (p_gie_clear) else $error("enable not cleared"); // RL22

   property p_pend_masked;
      pend_q && !EXT_IRQ_EN |=> !PM_EXCEPTION;
   endproperty
   a_pend_masked: assert property (p_pend_masked) else $error("exception while masked"); // RL10

   property p_pend_taken;
      pend_q && EXT_IRQ_EN && !PM_EXC_TAKEN ##1 !PM_EXC_TAKEN |-> PM_EXCEPTION;
   endproperty
   a_pend_taken: assert property (p_pend_taken) else $error("exception not raised"); // RL10

   property p_freeze;
      s_quiet_counters |=> cnt1 == $past(cnt1) && cnt4 == $past(cnt4);
   endproperty
   a_freeze: assert property (p_freeze) else $error("frozen counter moved"); // RL11

   property p_tb_count;
      run && !SPR_WR && sel1 == 7'(CODE_TB) && tb_rise |=> cnt1 == $past(cnt1) + 32'h1;
   endproperty
   a_tb_count: assert property (p_tb_count) else $error("time-base rise missed"); // RL15

   property p_dispatch_two;
      run && !SPR_WR && sel2 == 6'h04 && EV_DISPATCH == 2'h2 |=> cnt2 == $past(cnt2) + 32'h2;
   endproperty
   a_dispatch_two: assert property (p_dispatch_two) else $error("dual dispatch miscount"); // RL25

   property p_hold_code;
      !SPR_WR && sel1 == 7'h00 && sel3 == 5'h00 |=> cnt1 == $past(cnt1) && cnt3 == $past(cnt3);
   endproperty
   a_hold_code: assert property (p_hold_code) else $error("code 0 did not hold"); // RL14
endmodule
`default_nettype wire

// ### tb/core_events.sv
// core-side model: event sources, time base and exception acknowledge
`default_nettype none
module core_events
   import perf_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic nrst, // async reset, active low
   input wire logic burst, // every event fires while high
   input wire logic [0:31] tb_step, // time base advance per burst cycle
   input wire logic pm_exc, // monitor exception request
   output logic pm_taken, // exception taken, one-cycle pulse
   output logic [1:0] complete, // completions per cycle
   output logic [1:0] dispatch, // dispatches per cycle
   output logic one_evt, // all single-bit events
   output logic [7:0] lat, // latency of a finished load miss
   output logic [0:31] tb_lower, // time base lower word
   output logic [31:0] set_evt // per-code events of counters three and four
);
   timeunit 1ns;
   timeprecision 1ps;

   assign complete = burst ? 2'h2 : 2'h0;
   assign dispatch = burst ? 2'h2 : 2'h0;
   assign one_evt = burst;
   // 32 cycles sits just between thresholds 31 and 32
   assign lat = burst ? 8'h20 : 8'h00;
   assign set_evt = {32{burst}};

   // time base moves only in a burst and parks at zero, so no stray rise
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tb_lower <= 32'h0000_0000;
         pm_taken <= 1'b0;
      end else begin
         tb_lower <= burst ? tb_lower + tb_step : 32'h0000_0000;
         // take the exception one cycle after it is seen, as a pulse
         pm_taken <= pm_exc & !pm_taken;
      end
   end
endmodule
`default_nettype wire

// ### tb/tb_perf_event_counters.sv
// self-checking bench for the performance event counters
`default_nettype none
module tb_perf_event_counters;
   timeunit 1ns;
   timeprecision 1ps;
   import perf_pkg::*;

   localparam int K = 4; // burst length in cycles
   localparam logic [0:31] GIE = 32'h0400_0000; // primary bit 5
   localparam logic [0:31] FRZ = 32'h0200_0000; // primary bit 6
   localparam logic [0:31] C1IE = 32'h0000_8000; // primary bit 16
   localparam logic [0:31] SHIE = 32'h0000_4000; // primary bit 17

   logic clk, nrst, spr_wr, spr_rd, spr_rvalid, ext_en, taken, pm_exc, burst, one_evt;
   logic [9:0] spr_num; // register number
   logic [0:31] spr_wdata, spr_rdata, tb_lower, tb_step;
   logic [1:0] complete, dispatch; // multi-occurrence events
   logic [7:0] lat; // load miss latency
   logic [31:0] set_evt; // counters three and four events
   int errors = 0;
   int checked = 0;
   int cyc = 0;

   perf_event_counters dut (.CLOCK(clk), .NRST(nrst), .SPR_NUM(spr_num), .SPR_WR(spr_wr),
      .SPR_RD(spr_rd), .SPR_WDATA(spr_wdata), .SPR_RDATA(spr_rdata), .SPR_RVALID(spr_rvalid),
      .EV_COMPLETE(complete), .EV_DISPATCH(dispatch), .EV_BARRIER(one_evt),
      .EV_TABLE_SEARCH(one_evt), .EV_L2_HIT(one_evt), .EV_FETCH_EA(one_evt),
      .EV_BKPT_MATCH(one_evt), .EV_LOAD_MISS(one_evt), .EV_LOAD_LAT(lat),
      .EV_UNRES_BR(one_evt), .EV_STALL_BR2(one_evt), .TB_LOWER(tb_lower), .EV_SET3(set_evt),
      .EV_SET4(set_evt), .EXT_IRQ_EN(ext_en), .PM_EXC_TAKEN(taken), .PM_EXCEPTION(pm_exc));

   core_events core (.clk(clk), .nrst(nrst), .burst(burst), .tb_step(tb_step),
      .pm_exc(pm_exc), .pm_taken(taken), .complete(complete), .dispatch(dispatch),
      .one_evt(one_evt), .lat(lat), .tb_lower(tb_lower), .set_evt(set_evt));

   // free-running clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // cut a hang short well after the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         $display("BAD %0t run did not finish", $time);
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // word compare
   task automatic chk32(input logic [0:31] got, input logic [0:31] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t word %h expected %h", $time, got, exp);
      end
   endtask

   // flag compare
   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t flag %b expected %b", $time, got, exp);
      end
   endtask

   // move-to: one-cycle strobe, data taken at the same edge
   task automatic wr(input logic [9:0] n, input logic [0:31] d);
      @(posedge clk);
      spr_num <= n;
      spr_wdata <= d;
      spr_wr <= 1'b1;
      @(posedge clk);
      spr_wr <= 1'b0;
   endtask

   // move-from: answer stands for the one cycle after the strobe
   task automatic rd(input logic [9:0] n, output logic [0:31] d);
      @(posedge clk);
      spr_num <= n;
      spr_rd <= 1'b1;
      @(posedge clk);
      spr_rd <= 1'b0;
      #1;
      chk1(spr_rvalid, 1'b1);
      d = spr_rdata;
   endtask

   task automatic rdchk(input logic [9:0] n, input logic [0:31] e);
      logic [0:31] d;
      rd(n, d);
      chk32(d, e);
   endtask

   // bounded wait for the exception request to reach a level
   task automatic wait_pm(input logic e);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         #1;
         if (pm_exc === e) break;
      end
      chk1(pm_exc, e);
   endtask

   // K cycles of events; selection spans K+3 edges around it
   task automatic run_sel(input logic [9:0] sn, input logic [0:31] sv, input logic [9:0] cn,
      input logic [0:31] e);
      wr(cn, 32'h0000_0000);
      wr(sn, sv);
      @(posedge clk);
      burst <= 1'b1;
      repeat (K) @(posedge clk);
      burst <= 1'b0;
      wr(sn, 32'h0000_0000);
      rdchk(cn, e);
   endtask

   // expected count per code after one burst
   function automatic logic [0:31] amt(input int c);
      case (c)
         0: amt = 32'h0000_0000;
         1: amt = 32'(K + 3);
         2, 4: amt = 32'(2 * K);
         3: amt = 32'(K / 2);
         default: amt = 32'(K);
      endcase
   endfunction

   task automatic t_regs();
      logic [9:0] nums[8] = '{SPR_PRIMARY, SPR_CNT1, SPR_CNT2, SPR_SECOND, SPR_CNT3, SPR_CNT4,
         SPR_MIRROR0, SPR_MIRROR1};
      foreach (nums[i]) rdchk(nums[i], 32'h0000_0000);
      wr(SPR_SECOND, 32'hFFFF_FFFF);
      rdchk(SPR_SECOND, 32'hFFC0_0000);
      rdchk(SPR_MIRROR1, 32'hFFC0_0000);
      wr(SPR_MIRROR1, 32'h0000_0000);
      rdchk(SPR_SECOND, 32'hFFC0_0000);
      wr(SPR_SECOND, 32'h0000_0000);
      wr(SPR_PRIMARY, 32'h01BF_0000);
      rdchk(SPR_MIRROR0, 32'h01BF_0000);
      wr(SPR_MIRROR0, 32'h0000_0000);
      rdchk(SPR_PRIMARY, 32'h01BF_0000);
      rdchk(10'h3BB, 32'h0000_0000);
      wr(SPR_CNT2, 32'h7654_3210);
      rdchk(SPR_CNT2, 32'h7654_3210);
      $display("done regs");
   endtask

   task automatic t_codes();
      int picks[4] = '{TB_PICK0, TB_PICK1, TB_PICK2, TB_PICK3};
      logic [0:31] base; // threshold 31, time-base field 3
      base = 32'(31 << 16) | 32'(3 << 23);
      tb_step <= 32'h0000_0001;
      // defined codes only; threshold 31 lets the 32-cycle misses count
      for (int c = 0; c < N_CODES; c++) begin
         run_sel(SPR_PRIMARY, base | 32'(c << 6), SPR_CNT1, amt(c));
         run_sel(SPR_PRIMARY, base | 32'(c), SPR_CNT2, amt(c));
      end
      for (int f = 0; f < 4; f++) begin
         tb_step <= 32'h0000_0001 << (31 - picks[f]);
         run_sel(SPR_PRIMARY, 32'(f << 23) | 32'(CODE_TB << 6), SPR_CNT1, 32'(K / 2));
      end
      // latency equal to the threshold is not above it
      run_sel(SPR_PRIMARY, 32'(32 << 16) | 32'(10 << 6), SPR_CNT1, 32'h0000_0000);
      $display("done codes");
   endtask

   task automatic t_sel34();
      wr(SPR_PRIMARY, 32'h0001_0000);
      wr(SPR_CNT4, 32'h0000_0000);
      run_sel(SPR_SECOND, 32'(1 << 27) | 32'(4 << 22), SPR_CNT3, 32'(K + 3));
      rdchk(SPR_CNT4, 32'(2 * K));
      // codes above four come from the core's per-code event lines
      wr(SPR_CNT4, 32'h0000_0000);
      run_sel(SPR_SECOND, 32'(5 << 27) | 32'(9 << 22), SPR_CNT3, 32'(K));
      rdchk(SPR_CNT4, 32'(K));
      $display("done sel34");
   endtask

   task automatic t_irq();
      logic [0:31] v1, v2;
      wr(SPR_CNT1, 32'h7FFF_FFFE);
      wr(SPR_PRIMARY, GIE | FRZ | C1IE | 32'(1 << 6));
      repeat (6) @(posedge clk);
      #1;
      chk1(pm_exc, 1'b0);
      rdchk(SPR_PRIMARY, FRZ | C1IE | 32'(1 << 6));
      rd(SPR_CNT1, v1);
      rd(SPR_CNT1, v2);
      chk1(v1[0], 1'b1);
      chk32(v2, v1);
      @(posedge clk);
      ext_en <= 1'b1;
      wait_pm(1'b1);
      wait_pm(1'b0);
      // counter one still overflowed but its own enable is off
      wr(SPR_PRIMARY, GIE);
      repeat (4) @(posedge clk);
      #1;
      chk1(pm_exc, 1'b0);
      rdchk(SPR_PRIMARY, GIE);
      wr(SPR_PRIMARY, GIE | SHIE);
      wr(SPR_CNT3, 32'h8000_0000);
      wait_pm(1'b1);
      rdchk(SPR_PRIMARY, SHIE);
      wait_pm(1'b0);
      $display("done irq");
   endtask

   initial begin
      nrst = 1'b0;
      spr_num = 10'h000;
      spr_wr = 1'b0;
      spr_rd = 1'b0;
      spr_wdata = 32'h0000_0000;
      ext_en = 1'b0;
      burst = 1'b0;
      tb_step = 32'h0000_0000;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      t_regs();
      t_codes();
      t_sel34();
      t_irq();
      tally_and_finish();
   end
endmodule
`default_nettype wire
